// file: supervisor_pkg.sv
package supervisor_pkg;
	// Temperature-sense code: 10-bit fraction of supply, 1023 = 100 %
	localparam int TEMP_W = 10;
	localparam logic [9:0] HOT_TRIP = 10'h154;
	localparam logic [9:0] HOT_RESET = 10'h190;
	localparam logic [9:0] FAN_TRIP = 10'h190;
	localparam logic [9:0] FAN_RESET = 10'h1CD;
	// Start-up delay, 1000 us at 50 ns per cycle
	localparam int START_DELAY_US = 1000;
	localparam int CLK_NS = 50;
	localparam int START_DELAY_CYC = START_DELAY_US * 1000 / CLK_NS;
	localparam logic [2:0] PHASES_ALL = 3'h4;
	localparam logic [31:0] STAT_RESET = 32'h0000_0000;
	localparam logic [31:0] MASK_RESET = 32'h0000_0000;
	localparam logic [11:0] ADDR_STATUS = 12'h000;
	localparam logic [11:0] ADDR_MASK = 12'h004;
	localparam logic [11:0] ADDR_CTRL = 12'h008;
	localparam logic [11:0] ADDR_STATE = 12'h00C;
	localparam int EV_UV = 0;
	localparam int EV_OV = 1;
	localparam int EV_OC = 2;
	localparam int EV_HOT = 3;
	localparam int EV_FAN = 4;
	localparam int EV_RDY = 5;
	localparam int EV_W = 6;

	typedef enum {ST_OFF, ST_DELAY, ST_SOFTSTART, ST_RUN, ST_FAULT} run_state_t;

	typedef struct packed {
		logic over_current;
		logic over_voltage;
		logic under_voltage;
		logic in_window;
		logic softstart_done;
	} analog_flags_t;

	typedef struct packed {
		logic overtemp_alarm_od;
		logic cooling_request_od;
		logic regulator_ready_od;
	} od_pins_t;
endpackage

// file: hyst_alarm.sv
`timescale 1ns/10ps
module hyst_alarm
	import supervisor_pkg::*;
#(
	parameter int W = TEMP_W
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// Level
	input wire logic [W-1:0] level,
	input wire logic [W-1:0] trip_at,
	input wire logic [W-1:0] reset_at,
	// Alarm, high while tripped
	output logic tripped
);
	logic trip_q;
	logic trip_d;

	// Sense voltage falls as temperature rises; hysteresis keeps the pin from chattering
	always_comb begin
		trip_d = trip_q;
		if (level <= trip_at) begin
			trip_d = 1'b1;
		end else if (level >= reset_at) begin
			trip_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trip_q <= 1'b0;
		end else if (clk_en) begin
			trip_q <= trip_d;
		end
	end

	assign tripped = trip_q;
endmodule

// file: multiphase_supervisor_logic.sv
`timescale 1ns/10ps
module multiphase_supervisor_logic
	import supervisor_pkg::*;
#(
	parameter int DELAY_CYC = START_DELAY_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Supply and enables
	input wire logic supply_por_ok,
	input wire logic main_enable_in,
	input wire logic aux_rail_enable_in,
	// Analog comparators
	input wire analog_flags_t flags,
	input wire logic current_monitor_out,
	input wire logic code_transition,
	input wire logic [TEMP_W-1:0] temp_sense_in,
	// Configuration pins
	input wire logic phase_drive_2_tie,
	input wire logic phase_drive_3_tie,
	input wire logic phase_drive_4_tie,
	input wire logic freq_set_pin,
	input wire logic softstart_set_pin,
	input wire logic low_power_state_n,
	input wire logic [7:0] voltage_code,
	// Results
	output logic regulator_active,
	output logic softstart_start,
	output logic [2:0] active_phases,
	output logic continuous_conduction,
	output logic code_pullup_en,
	output logic [7:0] dac_code,
	output od_pins_t od_oe_n,
	output logic irq
);
	run_state_t st_q, st_d;
	logic [31:0] cnt_q, cnt_d;
	logic [2:0] cfg_phases_q, cfg_phases_d;
	logic fs_q, fs_d, ss_q, ss_d;
	logic pull_q, pull_d;
	logic [2:0] fault_q, fault_d;
	logic [2:0] phases_q, phases_d;
	logic ccm_q, ccm_d;
	logic [7:0] code_q, code_d;
	logic [EV_W-1:0] stat_q, stat_d, mask_q, mask_d;
	logic fault_hold_q, fault_hold_d;
	logic ready_q, ready_d;
	logic hot, fan;
	logic enables_ok, any_fault, oc_trip;
	logic [EV_W-1:0] ev;
	logic wr, rd;

	assign enables_ok = main_enable_in && aux_rail_enable_in;
	assign any_fault = |fault_q;
	// Monitor trip ignored during a code move: the reference slews and current spikes falsely
	assign oc_trip = flags.over_current || (current_monitor_out && !code_transition);

	hyst_alarm #(.W(TEMP_W)) u_hot (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.level(temp_sense_in), .trip_at(HOT_TRIP), .reset_at(HOT_RESET),
		.tripped(hot)
	);
	hyst_alarm #(.W(TEMP_W)) u_fan (
		.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
		.level(temp_sense_in), .trip_at(FAN_TRIP), .reset_at(FAN_RESET),
		.tripped(fan)
	);

	// Sequencer and fault latch
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		cfg_phases_d = cfg_phases_q;
		fs_d = fs_q;
		ss_d = ss_q;
		pull_d = pull_q;
		fault_d = fault_q | {oc_trip, flags.over_voltage, flags.under_voltage};
		case (st_q)
			ST_OFF: begin
				pull_d = 1'b0;
				cnt_d = '0;
				st_d = ST_DELAY;
			end
			ST_DELAY: begin
				// Straps caught at the end of each start-up delay, before soft-start
				if (cnt_q == 32'(DELAY_CYC - 1)) begin
					if (phase_drive_2_tie) begin
						cfg_phases_d = 3'h1;
					end else if (phase_drive_3_tie) begin
						cfg_phases_d = 3'h2;
					end else if (phase_drive_4_tie) begin
						cfg_phases_d = 3'h3;
					end else begin
						cfg_phases_d = PHASES_ALL;
					end
					fs_d = freq_set_pin;
					ss_d = softstart_set_pin;
					pull_d = 1'b1;
					st_d = ST_SOFTSTART;
				end else begin
					cnt_d = cnt_q + 32'h1;
				end
			end
			ST_SOFTSTART: begin
				if (enables_ok && !any_fault && flags.softstart_done) begin
					st_d = ST_RUN;
				end
			end
			ST_RUN: begin
				if (any_fault) begin
					st_d = ST_FAULT;
				end
			end
			ST_FAULT: begin
			end
			default: st_d = ST_OFF;
		endcase
		// Clearing does not wait for a run state: a fault seen during the delay is dropped too
		if (!enables_ok) begin
			fault_d = '0;
			if (st_q == ST_RUN || st_q == ST_FAULT || st_q == ST_SOFTSTART) begin
				st_d = ST_SOFTSTART;
			end
		end
		if (!supply_por_ok) begin
			fault_d = '0;
			st_d = ST_OFF;
			pull_d = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q <= ST_OFF;
			cnt_q <= '0;
			cfg_phases_q <= PHASES_ALL;
			fs_q <= 1'b0;
			ss_q <= 1'b0;
			pull_q <= 1'b0;
			fault_q <= '0;
		end else if (clk_en) begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			cfg_phases_q <= cfg_phases_d;
			fs_q <= fs_d;
			ss_q <= ss_d;
			pull_q <= pull_d;
			fault_q <= fault_d;
		end
	end

	// Phase selection and ready
	always_comb begin
		phases_d = cfg_phases_q;
		ccm_d = 1'b1;
		if (!low_power_state_n) begin
			phases_d = ss_q ? 3'h2 : 3'h1;
			ccm_d = 1'b0;
		end
		code_d = voltage_code;
		ready_d = (st_q == ST_RUN) && flags.in_window && !any_fault
			&& !flags.under_voltage && !flags.over_voltage && !oc_trip;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phases_q <= PHASES_ALL;
			ccm_q <= 1'b1;
			code_q <= 8'h00;
			ready_q <= 1'b0;
		end else if (clk_en) begin
			phases_q <= phases_d;
			ccm_q <= ccm_d;
			code_q <= code_d;
			ready_q <= ready_d;
		end
	end

	// APB: status (write one to clear), mask, control, state
	assign wr = psel && penable && pwrite && clk_en;
	assign rd = psel && !pwrite;
	assign ev = {ready_q, fan, hot, fault_q};

	always_comb begin
		mask_d = mask_q;
		fault_hold_d = fault_hold_q;
		stat_d = stat_q;
		if (wr && paddr == ADDR_STATUS) begin
			stat_d = stat_q & ~pwdata[EV_W-1:0];
		end
		// Set wins over a simultaneous clear
		stat_d = stat_d | ev;
		if (wr && paddr == ADDR_MASK) begin
			mask_d = pwdata[EV_W-1:0];
		end
		if (wr && paddr == ADDR_CTRL) begin
			fault_hold_d = pwdata[0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q <= STAT_RESET[EV_W-1:0];
			mask_q <= MASK_RESET[EV_W-1:0];
			fault_hold_q <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (clk_en) begin
			stat_q <= stat_d;
			mask_q <= mask_d;
			fault_hold_q <= fault_hold_d;
			if (rd && !penable) begin
				case (paddr)
					ADDR_STATUS: prdata <= {26'h0, stat_q};
					ADDR_MASK: prdata <= {26'h0, mask_q};
					ADDR_CTRL: prdata <= {31'h0, fault_hold_q};
					// State word: ccm, phases, straps, pull-up, ready, active from bit 9 down
					ADDR_STATE: prdata <= {22'h0, ccm_q, phases_q, cfg_phases_q,
						pull_q, ready_q, regulator_active};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign pready = clk_en;
	assign pslverr = psel && penable && !(paddr == ADDR_STATUS || paddr == ADDR_MASK
		|| paddr == ADDR_CTRL || paddr == ADDR_STATE);
	assign irq = |(stat_q & mask_q);

	// Software hold keeps the regulator idle without touching the enables
	// Supply is checked directly: the state still shows run in the cycle it drops
	assign regulator_active = (st_q == ST_SOFTSTART || st_q == ST_RUN) && enables_ok
		&& supply_por_ok && !any_fault && !fault_hold_q;
	assign softstart_start = regulator_active && st_q == ST_SOFTSTART;
	assign active_phases = phases_q;
	assign continuous_conduction = ccm_q;
	assign code_pullup_en = pull_q;
	assign dac_code = code_q;
	// Open drain: enable low means the pin is pulled low
	assign od_oe_n.regulator_ready_od = ready_q;
	assign od_oe_n.overtemp_alarm_od = hot;
	assign od_oe_n.cooling_request_od = fan;

	latched_fault_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && flags.over_voltage && supply_por_ok && enables_ok
		|=> fault_q[1]) else $error("overvoltage not latched");
	ready_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && oc_trip |=> !ready_q) else $error("ready high on overcurrent");
	uv_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && flags.under_voltage |=> !ready_q) else $error("ready on undervoltage");
	code_mask_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && current_monitor_out && code_transition && !flags.over_current
		&& fault_q == 3'h0 && supply_por_ok && enables_ok && !flags.over_voltage
		&& !flags.under_voltage |=> fault_q[2] == 1'b0) else $error("trip not masked");
	clear_en_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !main_enable_in && supply_por_ok && st_q == ST_RUN |=> fault_q == 3'h0
		&& st_q == ST_SOFTSTART) else $error("enable drop not clearing");
	por_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !supply_por_ok |=> st_q == ST_OFF && !regulator_active)
		else $error("not off without supply");
	psi_phase_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !low_power_state_n |=> active_phases == {1'b0, ss_q, !ss_q})
		else $error("low power decode wrong");
	restore_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && $rose(low_power_state_n) |-> ##1 active_phases == cfg_phases_q)
		else $error("phases not restored");
	active_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		regulator_active |-> enables_ok && supply_por_ok && !any_fault)
		else $error("active without permission");
	ready_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
		ready_q |-> $past(st_q == ST_RUN) && $past(flags.in_window))
		else $error("ready without run");
	pullup_late_a: assert property (@(posedge pclk) disable iff (!presetn)
		pull_q |-> st_q != ST_OFF && st_q != ST_DELAY) else $error("early pull-up");
	strap_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && st_q != ST_DELAY |=> $stable(cfg_phases_q))
		else $error("straps moved after latch");
	ccm_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && !low_power_state_n |=> !continuous_conduction)
		else $error("low power kept continuous mode");
	hot_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && temp_sense_in <= HOT_TRIP |=> od_oe_n.overtemp_alarm_od)
		else $error("hot alarm not released");
	fan_alarm_a: assert property (@(posedge pclk) disable iff (!presetn)
		clk_en && temp_sense_in <= FAN_TRIP |=> od_oe_n.cooling_request_od)
		else $error("fan alarm not released");

	run_c: cover property (@(posedge pclk) st_q == ST_SOFTSTART ##1 st_q == ST_RUN);
	clear_c: cover property (@(posedge pclk) st_q == ST_FAULT ##1 st_q == ST_SOFTSTART);
	fault_c: cover property (@(posedge pclk) st_q == ST_RUN ##1 st_q == ST_FAULT);
	psi_c: cover property (@(posedge pclk) $fell(low_power_state_n));
	hot_c: cover property (@(posedge pclk) $rose(hot));
endmodule

// file: power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model
	import supervisor_pkg::*;
#(
	parameter int SS_CYC = 8
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Controller state
	input wire logic regulator_active,
	input wire logic softstart_start,
	// Injected faults: oc, ov, uv
	input wire logic [2:0] fault_in,
	// Comparator outputs
	output analog_flags_t flags
);
	logic [7:0] ramp_q, ramp_d;
	logic done;
	// Output collapses whenever the controller idles, so the ramp starts over
	always_comb begin
		ramp_d = ramp_q;
		if (!regulator_active) begin
			ramp_d = 8'h00;
		end else if (softstart_start && ramp_q < SS_CYC[7:0]) begin
			ramp_d = ramp_q + 8'h01;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_q <= 8'h00;
		end else begin
			ramp_q <= ramp_d;
		end
	end
	assign done = (ramp_q == SS_CYC[7:0]);
	assign flags = {fault_in, done && !fault_in[0], done};
endmodule

// file: multiphase_supervisor_logic_tb.sv
`timescale 1ns/10ps
module multiphase_supervisor_logic_tb import supervisor_pkg::*;;
	localparam int DLY = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, irq;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic supply_por_ok, main_enable_in, aux_rail_enable_in, current_monitor_out;
	logic code_transition, freq_set_pin, softstart_set_pin, low_power_state_n;
	logic phase_drive_2_tie, phase_drive_3_tie, phase_drive_4_tie;
	logic regulator_active, softstart_start, continuous_conduction, code_pullup_en;
	logic [2:0] active_phases, flt, ex;
	logic [9:0] temp_sense_in;
	logic [9:0] tv[4] = '{10'h180, 10'h140, 10'h1A0, 10'h1E0};
	logic [1:0] te[4] = '{2'h1, 2'h3, 2'h1, 2'h0};
	logic [7:0] voltage_code, dac_code;
	analog_flags_t flags;
	od_pins_t od_oe_n;
	int err_count, total_checks, cyc;

	multiphase_supervisor_logic #(.DELAY_CYC(DLY)) DUT (.pclk, .presetn, .clk_en(1'b1),
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.supply_por_ok, .main_enable_in, .aux_rail_enable_in, .flags, .current_monitor_out,
		.code_transition, .temp_sense_in, .phase_drive_2_tie, .phase_drive_3_tie,
		.phase_drive_4_tie, .freq_set_pin, .softstart_set_pin, .low_power_state_n,
		.voltage_code, .regulator_active, .softstart_start, .active_phases,
		.continuous_conduction, .code_pullup_en, .dac_code, .od_oe_n, .irq);
	power_stage_model PSM (.pclk, .presetn, .regulator_active, .softstart_start,
		.fault_in(flt), .flags);

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Hold the whole request until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		int k;
		k = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) err_count++;
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wait_rdy(input logic v);
		int k;
		k = 0;
		while (od_oe_n.regulator_ready_od !== v && k < 200) begin
			@(posedge pclk);
			k++;
		end
		chk("ready", od_oe_n.regulator_ready_od, v);
	endtask

	task automatic toggle(input bit aux);
		if (aux) aux_rail_enable_in <= 1'b0;
		else main_enable_in <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("active", regulator_active, 0);
		aux_rail_enable_in <= 1'b1;
		main_enable_in <= 1'b1;
		@(posedge pclk);
		chk("softstart", softstart_start, 1);
		wait_rdy(1'b1);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			err_count++;
			end_sim();
		end
	end

	initial begin
		{psel, penable, pwrite, current_monitor_out, code_transition, presetn} = '0;
		{phase_drive_2_tie, phase_drive_3_tie, phase_drive_4_tie} = '0;
		{freq_set_pin, softstart_set_pin, paddr, pwdata, flt} = '0;
		{supply_por_ok, main_enable_in, aux_rail_enable_in, low_power_state_n} = '1;
		temp_sense_in = 10'h3FF;
		voltage_code = 8'h5A;
		repeat (16) @(posedge pclk);
		chk("oe", od_oe_n, 3'h0);
		chk("pullup", code_pullup_en, 0);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
		chk("early ready", od_oe_n.regulator_ready_od, 0);
		wait_rdy(1'b1);
		chk("active", regulator_active, 1);
		chk("pullup", code_pullup_en, 1);
		chk("dac", dac_code, 8'h5A);
		apb(1'b0, ADDR_MASK, 32'h0);
		chk("mask", rd, MASK_RESET);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", {rd[30:0], err}, 1);
		apb(1'b1, ADDR_MASK, 32'h4);
		apb(1'b1, ADDR_STATUS, 32'h3F);
		// Monitor clamp during a code move must not trip
		code_transition <= 1'b1;
		current_monitor_out <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("ready", od_oe_n.regulator_ready_od, 1);
		apb(1'b0, ADDR_STATUS, 32'h0);
		chk("oc", rd[2], 0);
		code_transition <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("ready", od_oe_n.regulator_ready_od, 0);
		chk("irq", irq, 1);
		current_monitor_out <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("ready", od_oe_n.regulator_ready_od, 0);
		toggle(1'b0);
		apb(1'b1, ADDR_STATUS, 32'h4);
		chk("irq", irq, 0);
		for (int i = 0; i < 3; i++) begin
			flt <= 3'h1 << i;
			repeat (4) @(posedge pclk);
			chk("ready", od_oe_n.regulator_ready_od, 0);
			flt <= 3'h0;
			repeat (4) @(posedge pclk);
			chk("ready", od_oe_n.regulator_ready_od, 0);
			apb(1'b0, ADDR_STATUS, 32'h0);
			chk("status", rd[i], 1);
			toggle(i[0]);
		end
		supply_por_ok <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("active", regulator_active, 0);
		supply_por_ok <= 1'b1;
		wait_rdy(1'b1);
		voltage_code <= 8'hA5;
		repeat (2) @(posedge pclk);
		chk("dac", dac_code, 8'hA5);
		// Software hold idles the regulator; no soft-start follows, and writing 0 to control ends it
		apb(1'b1, ADDR_CTRL, 32'h1);
		chk("hold", regulator_active, 0);
		repeat (4) @(posedge pclk);
		chk("ready", od_oe_n.regulator_ready_od, 0);
		apb(1'b0, ADDR_CTRL, 32'h0);
		chk("ctrl", rd, 32'h1);
		apb(1'b0, ADDR_STATE, 32'h0);
		chk("state", rd, 32'h0000_0324);
		apb(1'b1, ADDR_CTRL, 32'h0);
		for (int i = 0; i < 4; i++) begin
			temp_sense_in <= tv[i];
			repeat (4) @(posedge pclk);
			chk("alarms", {od_oe_n.overtemp_alarm_od, od_oe_n.cooling_request_od}, te[i]);
		end
		for (int i = 0; i < 4; i++) begin
			{phase_drive_4_tie, phase_drive_3_tie, phase_drive_2_tie} <= (i == 0) ? 3'h0 : 3'h1 << (i - 1);
			{freq_set_pin, softstart_set_pin} <= i[1:0];
			ex = (i == 0) ? 3'h4 : i[2:0];
			presetn <= 1'b0;
			repeat (2) @(posedge pclk);
			presetn <= 1'b1;
			repeat (DLY + 8) @(posedge pclk);
			// Straps move after the latch point and must be ignored
			{phase_drive_4_tie, phase_drive_3_tie, phase_drive_2_tie} <= (i == 2) ? 3'h1 : 3'h2;
			{freq_set_pin, softstart_set_pin} <= ~i[1:0];
			repeat (2) @(posedge pclk);
			chk("phases", active_phases, ex);
			low_power_state_n <= 1'b0;
			repeat (3) @(posedge pclk);
			chk("lp phases", active_phases, i[0] ? 2 : 1);
			chk("ccm", continuous_conduction, 0);
			low_power_state_n <= 1'b1;
			repeat (3) @(posedge pclk);
			chk("phases", active_phases, ex);
			chk("ccm", continuous_conduction, 1);
		end
		end_sim();
	end
endmodule
